/* csrw_pkg.sv */
/*
 constants for the supervisor: timing figures and derived cycle counts.
 assumes a 20 mhz system clock.
*/
package csrw_pkg;
   // clock rate in hz
   localparam int unsigned CLK_HZ        = 20_000_000;
   // reset stretch time in ms
   localparam int unsigned STRETCH_MS    = 200;
   // watchdog timeout in ms (1.6 s)
   localparam int unsigned WDOG_MS       = 1600;
   // derived cycle counts
   localparam int unsigned STRETCH_CYC   = STRETCH_MS * (CLK_HZ / 1000);
   localparam int unsigned WDOG_CYC      = WDOG_MS * (CLK_HZ / 1000);
   // counter width covering both counts
   localparam int unsigned CNT_W         = 32;
   // reset values of the active-low outputs
   localparam logic        RST_OUT_INIT  = 1'b0;
   localparam logic        WD_OUT_INIT   = 1'b0;
   localparam logic        PF_OUT_INIT   = 1'b0;
   // reset sequencer states
   typedef enum logic [1:0] {
      CSRW_HOLD,
      CSRW_STRETCH,
      CSRW_RUN
   } csrw_state_t;
endpackage : csrw_pkg

/* csrw_tmr_if.sv */
/*
 interface carrying a timer's clear and expiry.
 assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface csrw_tmr_if;
   logic clear;   // restart the count
   logic expired; // count reached its limit
   modport ctl (output clear, input expired);
   modport tmr (input clear, output expired);
endinterface : csrw_tmr_if

/* csrw_timer.sv */
/*
 saturating cycle timer: counts while not cleared, flags at limit.
 assumes clear is synchronous to clock.
*/
`timescale 1ns/10ps
module csrw_timer #(
   parameter int unsigned LIMIT = 4
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   // control
   csrw_tmr_if.tmr   tif
);
   logic [csrw_pkg::CNT_W-1:0] count;
   localparam logic [csrw_pkg::CNT_W-1:0] LIM_M1 =
      csrw_pkg::CNT_W'(LIMIT - 1);

   // counter, holds at LIMIT - 1
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         count <= '0;
      end else if (tif.clear) begin
         count <= '0;
      end else if (count != LIM_M1) begin
         count <= count + 1'b1;
      end
   end

   // expiry flag registered
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tif.expired <= 1'b0;
      end else begin
         tif.expired <= !tif.clear && (count == LIM_M1);
      end
   end
endmodule : csrw_timer

/* csrw_supervisor.sv */
/*
 cpu supervisor: stretched reset output, watchdog with latched
 timeout output, and a registered power-fail flag.
 the reset stretch and the watchdog timeout are counted in system
 clock cycles by two instances of the shared cycle timer.
 assumes all inputs are synchronous digital flags from an analog
 front end, and that sys_rst is released synchronously to clock.
*/
`timescale 1ns/10ps
module csrw_supervisor #(
   parameter int unsigned STRETCH_CYC = csrw_pkg::STRETCH_CYC,
   parameter int unsigned WDOG_CYC    = csrw_pkg::WDOG_CYC
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic sys_rst,
   // supply and comparator flags
   input  wire logic supply_low,
   input  wire logic power_fail_sense_in,
   // manual reset and watchdog inputs
   input  wire logic manual_reset_req_n,
   input  wire logic watchdog_kick_in,
   input  wire logic watchdog_kick_tristate,
   // supervisory outputs
   output logic      cpu_reset_n,
   output logic      watchdog_expired_n,
   output logic      power_fail_flag_n
);
   // sequencer state
   csrw_pkg::csrw_state_t state;
   csrw_pkg::csrw_state_t next_state;

   // timer links
   csrw_tmr_if            str_if ();
   csrw_tmr_if            wd_if ();

   // hold causes
   logic                  supply_hold;
   logic                  manual_hold;
   logic                  hold_cond;

   // kick tracking
   logic                  kick_prev;
   logic                  kick_edge;

   // watchdog clear sources
   logic                  clr_by_kick;
   logic                  clr_by_float;
   logic                  clr_by_reset;

   // next values of the registered outputs
   logic                  next_cpu_reset_n;
   logic                  next_wd_expired_n;
   logic                  next_pf_flag_n;

   // the limits are cycle counts; their defaults are the
   // nominal times at the package clock rate
   // stretch timer
   csrw_timer #(
      .LIMIT   (STRETCH_CYC)
   ) u_stretch (
      .clock   (clock),
      .sys_rst (sys_rst),
      .tif     (str_if)
   );

   csrw_timer #(
      .LIMIT   (WDOG_CYC)
   ) u_wdog (
      .clock   (clock),
      .sys_rst (sys_rst),
      .tif     (wd_if)
   );

   assign supply_hold = supply_low;

   assign manual_hold = !manual_reset_req_n;

   // both causes share one path, so a manual request during
   // low supply simply extends the same pulse
   assign hold_cond   = supply_hold || manual_hold;

   // sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         csrw_pkg::CSRW_HOLD: begin
            // leave hold once both causes are gone
            if (!hold_cond) begin
               next_state = csrw_pkg::CSRW_STRETCH;
            end
         end
         csrw_pkg::CSRW_STRETCH: begin
            if (hold_cond) begin
               // a new cause restarts the whole pulse
               next_state = csrw_pkg::CSRW_HOLD;
            end else if (str_if.expired) begin
               next_state = csrw_pkg::CSRW_RUN;
            end
         end
         csrw_pkg::CSRW_RUN: begin
            if (hold_cond) begin
               next_state = csrw_pkg::CSRW_HOLD;
            end
         end
         default: begin
            // unused code falls back to hold
            next_state = csrw_pkg::CSRW_HOLD;
         end
      endcase
   end

   // stretch counts only while in stretch
   assign str_if.clear = (state != csrw_pkg::CSRW_STRETCH) || hold_cond;

   // the sequencer wakes in hold, so reset is never released
   // without a full stretch after sys_rst
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state <= csrw_pkg::CSRW_HOLD;
      end else begin
         state <= next_state;
      end
   end

   // reset output high only in run
   assign next_cpu_reset_n = (next_state == csrw_pkg::CSRW_RUN);

   // reset output register
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cpu_reset_n <= csrw_pkg::RST_OUT_INIT;
      end else begin
         cpu_reset_n <= next_cpu_reset_n;
      end
   end

   // resets low: a high kick level at release reads as one
   // edge, which only clears the count early
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         kick_prev <= 1'b0;
      end else begin
         kick_prev <= watchdog_kick_in;
      end
   end

   // either edge of the kick input
   assign kick_edge = watchdog_kick_in != kick_prev;

   assign clr_by_kick = kick_edge;

   assign clr_by_float = watchdog_kick_tristate;

   assign clr_by_reset = (state != csrw_pkg::CSRW_RUN) ||
                         hold_cond;

   // any source restarts the timeout
   assign wd_if.clear = clr_by_kick || clr_by_float ||
                        clr_by_reset;

   // supply_low is tested first so it always wins over a
   // clear that falls in the same cycle
   // watchdog output next value
   always_comb begin
      next_wd_expired_n = watchdog_expired_n;
      if (supply_low) begin
         // forced low while supply is low
         next_wd_expired_n = 1'b0;
      end else if (wd_if.clear) begin
         next_wd_expired_n = 1'b1;
      end else if (wd_if.expired) begin
         next_wd_expired_n = 1'b0;
      end
   end

   // watchdog output register
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         watchdog_expired_n <= csrw_pkg::WD_OUT_INIT;
      end else begin
         watchdog_expired_n <= next_wd_expired_n;
      end
   end

   assign next_pf_flag_n = !power_fail_sense_in;

   // one register stage only; no filter and no latch, so
   // the flag may chatter if the comparator does
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         power_fail_flag_n <= csrw_pkg::PF_OUT_INIT;
      end else begin
         power_fail_flag_n <= next_pf_flag_n;
      end
   end

endmodule : csrw_supervisor

/* csrw_supervisor_asserts.sv */
/*
 concurrent checks on the supervisor ports.
 assumes it is bound onto csrw_supervisor and sees only its ports;
 the stretch check expects cpu_reset_n low at the one sample 19 cycles before it rises.
*/
`timescale 1ns/10ps
module csrw_sup_chk #(
   parameter int unsigned WDOG_CYC = 50
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // inputs
   input wire logic supply_low,
   input wire logic power_fail_sense_in,
   input wire logic manual_reset_req_n,
   input wire logic watchdog_kick_in,
   input wire logic watchdog_kick_tristate,
   // outputs
   input wire logic cpu_reset_n,
   input wire logic watchdog_expired_n,
   input wire logic power_fail_flag_n
);
   logic [7:0] idle;
   logic       kick_last;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // kick level one cycle back
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         kick_last <= 1'b0;
      end else begin
         kick_last <= watchdog_kick_in;
      end
   end
   // cycles with no clearing event
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         idle <= 8'h00;
      end else if (supply_low || !manual_reset_req_n
                   || watchdog_kick_tristate || !cpu_reset_n
                   || watchdog_kick_in != kick_last) begin
         idle <= 8'h00;
      end else if (idle != 8'hff) begin
         idle <= idle + 8'h01;
      end
   end
   chk_reset_hold: assert property (
      (supply_low || !manual_reset_req_n) |=> !cpu_reset_n)
      else $error("reset not held");
   chk_reset_stretch: assert property (
      $rose(cpu_reset_n) |-> !$past(cpu_reset_n, 19))
      else $error("stretch too short");
   chk_wd_forced: assert property (
      supply_low |=> !watchdog_expired_n)
      else $error("watchdog output not forced");
   chk_pf_follow: assert property (
      1'b1 |=> power_fail_flag_n == !$past(power_fail_sense_in))
      else $error("power fail flag");
   chk_kick_clears: assert property (
      $changed(watchdog_kick_in)
      |=> ##[0:1] (watchdog_expired_n || supply_low))
      else $error("kick did not clear");
   chk_float_off: assert property (
      watchdog_kick_tristate
      |=> ##[0:1] (watchdog_expired_n || supply_low))
      else $error("float did not disable");
   chk_wd_latch: assert property (
      !watchdog_expired_n && cpu_reset_n && manual_reset_req_n
      && !watchdog_kick_tristate
      && $stable({supply_low, watchdog_kick_in})
      |=> !watchdog_expired_n)
      else $error("timeout not latched");
   chk_wd_timeout: assert property (
      idle > WDOG_CYC + 4 |-> !watchdog_expired_n)
      else $error("timeout missed");
   chk_wd_early: assert property (
      idle != 8'h00 && idle < WDOG_CYC |-> watchdog_expired_n)
      else $error("timeout too early");
   cover property ($rose(cpu_reset_n));
   cover property ($fell(watchdog_expired_n));
   cover property ($fell(power_fail_flag_n));
endmodule : csrw_sup_chk
bind csrw_supervisor csrw_sup_chk #(
   .WDOG_CYC (WDOG_CYC)
) u_csrw_sup_chk (
   .clock                  (clock),
   .sys_rst                (sys_rst),
   .supply_low             (supply_low),
   .power_fail_sense_in    (power_fail_sense_in),
   .manual_reset_req_n     (manual_reset_req_n),
   .watchdog_kick_in       (watchdog_kick_in),
   .watchdog_kick_tristate (watchdog_kick_tristate),
   .cpu_reset_n            (cpu_reset_n),
   .watchdog_expired_n     (watchdog_expired_n),
   .power_fail_flag_n      (power_fail_flag_n)
);

/* csrw_host.sv */
/* host kicking the watchdog. assumes the bench gates it with kick_en. */
`timescale 1ns/10ps
module csrw_host (
   // control
   input wire logic clock,
   input wire logic kick_en,
   // kick line
   output logic     watchdog_kick_in
);
   logic [3:0] gap;
   initial begin
      watchdog_kick_in = 1'b0;
      gap = 4'h0;
      forever begin
         @(negedge clock);
         gap = gap + 4'h1;
         if (kick_en && gap == 4'h0) watchdog_kick_in = !watchdog_kick_in;
      end
   end
endmodule : csrw_host

/* csrw_supervisor_test.sv */
/*
 supervisor bench: one task per scenario, each judging its own results.
 assumes the instance runs a stretch of 20 and a timeout of 50 cycles.
*/
`timescale 1ns/10ps
module csrw_supervisor_test;
   // cycle counts handed to the design
   localparam int STR_CYC = 20;
   localparam int WD_CYC  = 50;
   // stimulus
   logic clock;
   logic sys_rst;
   logic supply_low;
   logic pf_sense;
   logic man_req_n;
   logic kick_en;
   logic kick_float;
   // responses
   logic kick;
   logic cpu_rst_n;
   logic wd_exp_n;
   logic pf_flag_n;
   // bookkeeping
   int   error_cnt;
   int   n_compared;

   csrw_supervisor #(
      .STRETCH_CYC (STR_CYC),
      .WDOG_CYC    (WD_CYC)
   ) u_csrw_supervisor (
      .clock                  (clock),
      .sys_rst                (sys_rst),
      .supply_low             (supply_low),
      .power_fail_sense_in    (pf_sense),
      .manual_reset_req_n     (man_req_n),
      .watchdog_kick_in       (kick),
      .watchdog_kick_tristate (kick_float),
      .cpu_reset_n            (cpu_rst_n),
      .watchdog_expired_n     (wd_exp_n),
      .power_fail_flag_n      (pf_flag_n)
   );

   csrw_host u_csrw_host (
      .clock            (clock),
      .kick_en          (kick_en),
      .watchdog_kick_in (kick)
   );

   task cmp(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task wt(input int n);
      repeat (n) @(negedge clock);
   endtask : wt

   task summarize;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize

   // release lands stretch plus two cycles after the cause ends
   task chk_stretch(input int waited);
      wt(STR_CYC + 1 - waited);
      cmp(cpu_rst_n, 1'b0);
      wt(1);
      cmp(cpu_rst_n, 1'b1);
   endtask : chk_stretch

   task t_supply;
      supply_low = 1'b1;
      wt(1);
      cmp(cpu_rst_n, 1'b0);
      cmp(wd_exp_n, 1'b0);
      wt(40);
      cmp(cpu_rst_n, 1'b0);
      supply_low = 1'b0;
      wt(1);
      cmp(wd_exp_n, 1'b1);
      chk_stretch(1);
   endtask : t_supply

   task t_manual;
      man_req_n = 1'b0;
      wt(1);
      cmp(cpu_rst_n, 1'b0);
      wt(40);
      cmp(cpu_rst_n, 1'b0);
      cmp(wd_exp_n, 1'b1);
      man_req_n = 1'b1;
      chk_stretch(0);
   endtask : t_manual

   // entered one half cycle after release; kick held still
   task t_wdog;
      kick_en = 1'b0;
      wt(WD_CYC);
      cmp(wd_exp_n, 1'b1);
      wt(1);
      cmp(wd_exp_n, 1'b0);
      wt(5);
      cmp(wd_exp_n, 1'b0);
      kick_en = 1'b1;
      wt(18);
      cmp(wd_exp_n, 1'b1);
      wt(80);
      cmp(wd_exp_n, 1'b1);
   endtask : t_wdog

   task t_float;
      kick_en = 1'b0;
      kick_float = 1'b1;
      wt(80);
      cmp(wd_exp_n, 1'b1);
      kick_float = 1'b0;
      kick_en = 1'b1;
   endtask : t_float

   task t_pf;
      for (int i = 0; i < 4; i++) begin
         pf_sense = i[0];
         wt(1);
         cmp(pf_flag_n, !i[0]);
      end
   endtask : t_pf

   // second reset in mid-run, then a full stretch again
   task t_sysrst;
      sys_rst = 1'b1;
      wt(2);
      cmp(cpu_rst_n, 1'b0);
      cmp(wd_exp_n, 1'b0);
      cmp(pf_flag_n, 1'b0);
      sys_rst = 1'b0;
      chk_stretch(0);
   endtask : t_sysrst
   // clock, 50 ns period
   initial begin
      clock = 1'b0;
      forever #25 clock = !clock;
   end
   // main sequence
   initial begin
      sys_rst    = 1'b1;
      supply_low = 1'b1;
      pf_sense   = 1'b0;
      man_req_n  = 1'b1;
      kick_en    = 1'b0;
      kick_float = 1'b0;
      error_cnt  = 0;
      n_compared = 0;
      wt(2);
      sys_rst = 1'b0;
      wt(2);
      t_supply;
      t_manual;
      t_wdog;
      t_float;
      t_pf;
      t_sysrst;
      summarize;
   end
   // hang guard, about ten times the expected run
   initial begin
      #200us;
      error_cnt++;
      summarize;
   end
endmodule : csrw_supervisor_test
